/* File: design/acc_ctrl.sv */
// Behaviour
// - interrupt and ADC trigger come from separate, independently programmed sense logic.
// - result can drive output pin, raise an interrupt, or start an ADC sequence.
// - output pin is plain general-purpose after reset; result only when alternate selected.
// - negative input is external only; positive is pin, shared input, or reference.
// - ladder disabled gives ground whatever the tap code holds.
// - wide range uses a 31-unit ladder, tap equals code plus 8.
// - narrow range uses a 23-unit ladder, tap equals code directly.
// - masked status, raw status, interrupt enable, and one reference control register.
// - writing one to the masked status bit clears the pending interrupt.
// - interrupt forwarded only while enabled; raw status records events regardless.
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_ctrl
    import acc_pkg::*;
#(
    parameter int ADDR_W = 8, // byte address width seen by the slave
    parameter int CODE_W = 4 // reference tap code width
) (
    input wire logic clk_i, // system clock, 200 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic ce_i, // clock enable, freezes all state when low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic compare_result_i, // raw comparator output
    output acc_src_t positive_source_select_o, // positive input mux setting
    output acc_ladder_t ladder_o, // reference ladder setting
    output logic compare_output_pin_o, // output pin level
    output logic compare_output_pin_oe_o, // output pin drive enable
    output logic pin_digital_input_enable_o, // digital input buffer on
    output logic irq_o, // level interrupt to the controller
    output logic adc_trigger_o // sequence start, one cycle per edge; held high in level mode
);

    // ---------------------------------------------
    // elaboration checks
    // ---------------------------------------------
    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("acc_ctrl: ADDR_W must be at least 8");
        end
        if (CODE_W != 4) begin : g_bad_code
            $error("acc_ctrl: ladder arithmetic serves a 4-bit code only");
        end
    endgenerate

    // ---------------------------------------------
    // functions
    // ---------------------------------------------

    // byte-lane merge of a write into a 32-bit image
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        lane_merge = (old_v & ~m) | (new_v & m);
    endfunction : lane_merge

    // tap and ladder size from the reference control fields
    function automatic acc_ladder_t ladder_of(input acc_ref_t r);
        acc_ladder_t l;
        l.ground = ~r.en;
        if (!r.en) begin
            l.units = 5'h00;
            l.tap = 5'h00;
        end else if (r.ladder_range_select) begin
            l.units = `ACC_LADDER_NARROW_UNITS;
            l.tap = {1'b0, r.code};
        end else begin
            l.units = `ACC_LADDER_WIDE_UNITS;
            l.tap = {1'b0, r.code} + `ACC_LADDER_WIDE_OFFSET;
        end
        ladder_of = l;
    endfunction : ladder_of

    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    acc_wb_req_t req;
    acc_ref_t ref_q;
    acc_ctl_t ctl_q;
    acc_pin_t pin_q;
    logic ris_q;
    logic inten_q;
    logic sync_a;
    logic sync_b;
    logic res_q;
    logic res_prev;

    // ---------------------------------------------
    // bus decode
    // ---------------------------------------------
    logic bus_req;
    logic wr_fire;
    logic hit_mis;
    logic hit_ris;
    logic hit_inten;
    logic hit_ref;
    logic hit_stat;
    logic hit_ctl;
    logic hit_pin;
    logic [31:0] rdata;

    // bundle the bus request so the decode reads from one carrier
    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.adr = wb_adr_i[7:0];
    assign req.dat = wb_dat_i;

    // upper address bits must be zero for any register to answer
    logic upper_zero;
    generate
        if (ADDR_W > 8) begin : g_upper
            assign upper_zero = (wb_adr_i[ADDR_W-1:8] == '0);
        end else begin : g_no_upper
            assign upper_zero = 1'b1;
        end
    endgenerate

    assign bus_req = req.cyc & req.stb;
    // a write lands on the edge at which the master sees ack
    assign wr_fire = bus_req & req.we & wb_ack_o;
    assign hit_mis = upper_zero & (req.adr == `ACC_OFF_MIS);
    assign hit_ris = upper_zero & (req.adr == `ACC_OFF_RIS);
    assign hit_inten = upper_zero & (req.adr == `ACC_OFF_INTEN);
    assign hit_ref = upper_zero & (req.adr == `ACC_OFF_REFCTL);
    assign hit_stat = upper_zero & (req.adr == `ACC_OFF_STAT);
    assign hit_ctl = upper_zero & (req.adr == `ACC_OFF_CTL);
    assign hit_pin = upper_zero & (req.adr == `ACC_OFF_PIN);

    // ---------------------------------------------
    // read image; reserved bits and unmapped addresses read zero
    // ---------------------------------------------
    logic [31:0] img_mis;
    logic [31:0] img_ris;
    logic [31:0] img_inten;
    logic [31:0] img_ref;
    logic [31:0] img_stat;
    logic [31:0] img_ctl;
    logic [31:0] img_pin;

    assign img_mis = {31'h0, ris_q & inten_q};
    assign img_ris = {31'h0, ris_q};
    assign img_inten = {31'h0, inten_q};
    assign img_ref = {22'h0, ref_q.en, ref_q.ladder_range_select, 4'h0, ref_q.code};
    assign img_stat = {30'h0, res_q, 1'b0};
    // bit 8 is a hole in the control layout, so fields are placed one by one
    assign img_ctl = {20'h0, ctl_q.toen, ctl_q.src, 1'b0, ctl_q.tslval, ctl_q.tsen,
                      ctl_q.islval, ctl_q.isen, ctl_q.inv, 1'b0};
    assign img_pin = {28'h0, pin_q};

    assign rdata = ({32{hit_mis}} & img_mis)
                 | ({32{hit_ris}} & img_ris)
                 | ({32{hit_inten}} & img_inten)
                 | ({32{hit_ref}} & img_ref)
                 | ({32{hit_stat}} & img_stat)
                 | ({32{hit_ctl}} & img_ctl)
                 | ({32{hit_pin}} & img_pin);

    // ---------------------------------------------
    // next values of software registers
    // ---------------------------------------------
    logic [31:0] wimg_inten;
    logic [31:0] wimg_ref;
    logic [31:0] wimg_ctl;
    logic [31:0] wimg_pin;
    logic mis_clear;
    logic next_inten;
    acc_ref_t next_ref;
    acc_ctl_t next_ctl;
    acc_pin_t next_pin;

    assign wimg_inten = lane_merge(img_inten, req.dat, req.sel);
    assign wimg_ref = lane_merge(img_ref, req.dat, req.sel);
    assign wimg_ctl = lane_merge(img_ctl, req.dat, req.sel);
    assign wimg_pin = lane_merge(img_pin, req.dat, req.sel);

    assign next_inten = (wr_fire & hit_inten) ? wimg_inten[`ACC_IRQ_BIT] : inten_q;
    // one reference control register steers the whole ladder
    assign next_ref = (wr_fire & hit_ref)
                    ? {wimg_ref[`ACC_REF_EN_BIT], wimg_ref[`ACC_REF_RNG_BIT],
                       wimg_ref[`ACC_REF_CODE_LSB +: 4]}
                    : ref_q;
    // source select field reset-defaults to the external pin
    assign next_ctl = (wr_fire & hit_ctl)
                    ? {wimg_ctl[`ACC_CTL_TOEN_BIT], wimg_ctl[`ACC_CTL_SRC_LSB +: 2],
                       wimg_ctl[`ACC_CTL_TSLVAL_BIT], wimg_ctl[`ACC_CTL_TSEN_LSB +: 2],
                       wimg_ctl[`ACC_CTL_ISLVAL_BIT], wimg_ctl[`ACC_CTL_ISEN_LSB +: 2],
                       wimg_ctl[`ACC_CTL_INV_BIT]}
                    : ctl_q;
    assign next_pin = (wr_fire & hit_pin)
                    ? acc_pin_t'(wimg_pin[`ACC_PIN_DEN_BIT:`ACC_PIN_AF_BIT])
                    : pin_q;

    // write-one-to-clear on the masked status bit
    assign mis_clear = wr_fire & hit_mis & req.sel[0] & req.dat[`ACC_IRQ_BIT];

    // ---------------------------------------------
    // bus slave: ack one cycle after the request, dropped after one cycle
    // ---------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= (bus_req & ~wb_ack_o & ~req.we) ? rdata : 32'h0000_0000;
        end
    end

    // software register storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inten_q <= `ACC_RST_IRQ;
            ref_q <= `ACC_RST_REF;
            ctl_q <= `ACC_RST_CTL;
            pin_q <= `ACC_RST_PIN;
        end else if (ce_i) begin
            inten_q <= next_inten;
            ref_q <= next_ref;
            ctl_q <= next_ctl;
            pin_q <= next_pin;
        end
    end

    // ---------------------------------------------
    // result synchroniser and polarity
    // ---------------------------------------------

    // two flops before anything looks at the result
    // an invert change can itself look like an edge; program before enabling sense
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            res_q <= 1'b0;
            res_prev <= 1'b0;
        end else if (ce_i) begin
            sync_a <= compare_result_i;
            sync_b <= sync_a;
            res_q <= sync_b ^ ctl_q.inv;
            res_prev <= res_q;
        end
    end

    // ---------------------------------------------
    // independent interrupt and trigger sense
    // ---------------------------------------------
    logic int_hit;
    logic trig_hit;

    // interrupt path has its own sense choice and level
    acc_sense u_int_sense (
        .cur_i(res_q),
        .prev_i(res_prev),
        .mode_i(ctl_q.isen),
        .level_i(ctl_q.islval),
        .hit_o(int_hit)
    );

    // trigger path uses separate fields, so e.g. rise irq, fall trigger
    acc_sense u_trig_sense (
        .cur_i(res_q),
        .prev_i(res_prev),
        .mode_i(ctl_q.tsen),
        .level_i(ctl_q.tslval),
        .hit_o(trig_hit)
    );

    // ---------------------------------------------
    // interrupt status
    // ---------------------------------------------
    logic next_ris;

    // raw status sets regardless of enable; a set beats a same-cycle clear
    assign next_ris = int_hit | (ris_q & ~mis_clear);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ris_q <= `ACC_RST_IRQ;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            ris_q <= next_ris;
            irq_o <= next_ris & next_inten;
        end
    end

    // ---------------------------------------------
    // trigger output
    // ---------------------------------------------

    // trigger needs the enable bit; in level mode it repeats each cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_trigger_o <= 1'b0;
        end else if (ce_i) begin
            adc_trigger_o <= trig_hit & ctl_q.toen;
        end
    end

    // ---------------------------------------------
    // output pin
    // ---------------------------------------------
    logic next_pin_val;
    logic next_pin_oe;

    // pin is ordinary GPIO until the alternate function is picked
    assign next_pin_val = next_pin.af ? res_q : next_pin.gpo;
    assign next_pin_oe = next_pin.af | next_pin.goe;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_output_pin_o <= 1'b0;
            compare_output_pin_oe_o <= 1'b0;
            pin_digital_input_enable_o <= 1'b0;
        end else if (ce_i) begin
            compare_output_pin_o <= next_pin_val;
            compare_output_pin_oe_o <= next_pin_oe;
            pin_digital_input_enable_o <= next_pin.den;
        end
    end

    // ---------------------------------------------
    // analog setting outputs
    // ---------------------------------------------

    // negative input has no mux; only the positive source is steered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            positive_source_select_o <= ACC_SRC_PIN;
            ladder_o <= '0;
        end else if (ce_i) begin
            positive_source_select_o <= next_ctl.src;
            ladder_o <= ladder_of(next_ref);
        end
    end

endmodule : acc_ctrl

/* File: design/acc_map.svh */
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define ACC_OFF_MIS 8'h00
`define ACC_OFF_RIS 8'h04
`define ACC_OFF_INTEN 8'h08
`define ACC_OFF_REFCTL 8'h10
`define ACC_OFF_STAT 8'h20
`define ACC_OFF_CTL 8'h24
`define ACC_OFF_PIN 8'h28

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define ACC_IRQ_BIT 0
`define ACC_REF_CODE_LSB 0
`define ACC_REF_RNG_BIT 8
`define ACC_REF_EN_BIT 9
`define ACC_CTL_INV_BIT 1
`define ACC_CTL_ISEN_LSB 2
`define ACC_CTL_ISLVAL_BIT 4
`define ACC_CTL_TSEN_LSB 5
`define ACC_CTL_TSLVAL_BIT 7
`define ACC_CTL_SRC_LSB 9
`define ACC_CTL_TOEN_BIT 11
`define ACC_STAT_VAL_BIT 1
`define ACC_PIN_AF_BIT 0
`define ACC_PIN_GPO_BIT 1
`define ACC_PIN_GOE_BIT 2
`define ACC_PIN_DEN_BIT 3

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define ACC_RST_REF 6'h00
`define ACC_RST_CTL 10'h000
`define ACC_RST_PIN 4'h0
`define ACC_RST_IRQ 1'h0

// ---------------------------------------------
// ladder constants, in resistor units
// ---------------------------------------------
`define ACC_LADDER_WIDE_UNITS 5'h1F
`define ACC_LADDER_WIDE_OFFSET 5'h08
`define ACC_LADDER_NARROW_UNITS 5'h17

`endif

/* File: design/acc_pkg.sv */
package acc_pkg;

    // ---------------------------------------------
    // sense choices for interrupt and trigger paths
    // ---------------------------------------------
    typedef enum logic [1:0] {
        ACC_SENSE_LEVEL = 2'b00,
        ACC_SENSE_FALL = 2'b01,
        ACC_SENSE_RISE = 2'b10,
        ACC_SENSE_BOTH = 2'b11
    } acc_sense_t;

    // positive input source; code 2'b11 is reserved
    typedef enum logic [1:0] {
        ACC_SRC_PIN = 2'b00,
        ACC_SRC_SHARED = 2'b01,
        ACC_SRC_REF = 2'b10,
        ACC_SRC_RSVD = 2'b11
    } acc_src_t;

    typedef struct packed {
        logic en;
        logic ladder_range_select;
        logic [3:0] code;
    } acc_ref_t;

    typedef struct packed {
        logic toen;
        acc_src_t src;
        logic tslval;
        acc_sense_t tsen;
        logic islval;
        acc_sense_t isen;
        logic inv;
    } acc_ctl_t;

    typedef struct packed {
        logic den;
        logic goe;
        logic gpo;
        logic af;
    } acc_pin_t;

    // ladder setting handed to the analog reference
    typedef struct packed {
        logic ground;
        logic [4:0] units;
        logic [4:0] tap;
    } acc_ladder_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } acc_wb_req_t;

endpackage : acc_pkg

/* File: design/acc_sense.sv */
`timescale 1ns/1ps

// ---------------------------------------------
// edge / level sense on a synchronised result
// ---------------------------------------------
module acc_sense
    import acc_pkg::*;
(
    input wire logic cur_i, // result this cycle
    input wire logic prev_i, // result one cycle earlier
    input wire acc_sense_t mode_i, // sense choice
    input wire logic level_i, // active level in level mode
    output logic hit_o // event seen this cycle
);

    logic rise;
    logic fall;

    // edges compare two already synchronised samples
    assign rise = cur_i & ~prev_i;
    assign fall = ~cur_i & prev_i;

    always_comb begin
        unique case (mode_i)
            ACC_SENSE_LEVEL: hit_o = (cur_i == level_i);
            ACC_SENSE_FALL: hit_o = fall;
            ACC_SENSE_RISE: hit_o = rise;
            ACC_SENSE_BOTH: hit_o = rise | fall;
        endcase
    end

endmodule : acc_sense

/* File: testbench/acc_ctrl_checker.sv */
`timescale 1ns/1ps

module acc_ctrl_checker
    import acc_pkg::*;
#(
    parameter int ADDR_W = 8, // byte address width
    parameter int CODE_W = 4 // tap code width
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic ce_i, // clock enable
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire acc_src_t positive_source_select_o, // source mux
    input wire acc_ladder_t ladder_o, // ladder setting
    input wire logic compare_output_pin_oe_o, // pin drive enable
    input wire logic irq_o, // interrupt
    input wire logic adc_trigger_o // trigger pulse
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    // a frozen clock enable holds ack, so both steps need ce_i high
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_ack_live;
        wb_ack_o && ce_i;
    endsequence
    chk_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    chk_ack_single: assert property (s_ack_live |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without a request");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside the ack cycle");

    // ----------------------------------------
    // reference ladder and reset state
    // ----------------------------------------
    chk_ladder_gnd: assert property (ladder_o.ground |->
        ladder_o.units == 5'h00 && ladder_o.tap == 5'h00)
        else $error("grounded ladder still selects a tap");
    chk_ladder_wide: assert property (ladder_o.units == 5'h1F |->
        !ladder_o.ground && ladder_o.tap >= 5'h08 && ladder_o.tap <= 5'h17)
        else $error("wide ladder tap out of span");
    chk_ladder_narrow: assert property (ladder_o.units == 5'h17 |->
        !ladder_o.ground && ladder_o.tap <= 5'h0F)
        else $error("narrow ladder tap out of span");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !adc_trigger_o &&
        !compare_output_pin_oe_o && positive_source_select_o == ACC_SRC_PIN)
        else $error("outputs active right after reset");
endmodule : acc_ctrl_checker

bind acc_ctrl acc_ctrl_checker #(.ADDR_W(ADDR_W), .CODE_W(CODE_W)) acc_ctrl_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .positive_source_select_o(positive_source_select_o),
    .ladder_o(ladder_o), .compare_output_pin_oe_o(compare_output_pin_oe_o), .irq_o(irq_o),
    .adc_trigger_o(adc_trigger_o));

/* File: testbench/acc_far_end.sv */
`timescale 1ns/1ps

module acc_far_end (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic trigger_i, // sequence start from the block
    output logic [15:0] start_cnt_o // sequence starts taken
);
    // the sequencer starts once per cycle the trigger is seen high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_cnt_o <= 16'h0000;
        end else if (trigger_i) begin
            start_cnt_o <= start_cnt_o + 16'h0001;
        end
    end
endmodule : acc_far_end

/* File: testbench/comparator_control_logic_bench.sv */
`timescale 1ns/1ps
`include "acc_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module comparator_control_logic_bench;
    import acc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] lanes = 4'hF;
    logic res = 1'b1;
    logic [31:0] rdat;
    logic ack;
    acc_src_t src;
    acc_ladder_t ladder;
    logic pin;
    logic pin_oe;
    logic den;
    logic irq;
    logic trig;
    logic [15:0] starts;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;

    acc_ctrl acc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .compare_result_i(res),
        .positive_source_select_o(src), .ladder_o(ladder), .compare_output_pin_o(pin),
        .compare_output_pin_oe_o(pin_oe), .pin_digital_input_enable_o(den), .irq_o(irq),
        .adc_trigger_o(trig));
    acc_far_end acc_far_end_i (.clk_i(clk_i), .rst_i(rst_i), .trigger_i(trig),
        .start_cnt_o(starts));

    // ----------------------------------------
    // clock, timeout, verdict
    // ----------------------------------------
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // the whole run needs about 260 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------
    // bus and stimulus helpers
    // ----------------------------------------
    // request held until ack is sampled, then released for one idle cycle;
    // only the bench timeout ends a wait that never sees ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask : rchk

    // result high for hi cycles, then low long enough to pass the synchroniser
    task automatic pulse(input int hi);
        res <= 1'b1;
        repeat (hi) @(posedge clk_i);
        res <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask : pulse

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] a[8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24, 8'h28, 8'h0C};
        logic [31:0] e[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
        wr(`ACC_OFF_RIS, 32'hFFFFFFFF);
        wr(`ACC_OFF_STAT, 32'hFFFFFFFF);
        wr(8'h0C, 32'hFFFFFFFF);
        // default level-low sense latches the raw bit while the synchroniser fills
        wr(`ACC_OFF_MIS, 32'h1);
        for (int i = 0; i < 8; i++) begin
            rchk(a[i], e[i]);
        end
        `CHK(src, ACC_SRC_PIN)
        `CHK(pin_oe, 1'b0)
    endtask : t_regs

    task automatic t_ladder();
        logic [31:0] v[4] = '{32'h005, 32'h20F, 32'h200, 32'h30A};
        acc_ladder_t e;
        foreach (v[i]) begin
            e = '{1'b1, 5'h00, 5'h00};
            if (v[i][9]) begin
                e.ground = 1'b0;
                e.units = v[i][8] ? 5'h17 : 5'h1F;
                e.tap = {1'b0, v[i][3:0]} + (v[i][8] ? 5'h00 : 5'h08);
            end
            wr(`ACC_OFF_REFCTL, v[i]);
            `CHK(ladder, e)
            rchk(`ACC_OFF_REFCTL, v[i]);
        end
    endtask : t_ladder

    task automatic t_source();
        for (int s = 0; s < 3; s++) begin
            wr(`ACC_OFF_CTL, 32'h8 | 32'(s << 9));
            `CHK(src, acc_src_t'(s))
        end
    endtask : t_source

    task automatic t_irq();
        wr(`ACC_OFF_INTEN, 32'h0);
        res <= 1'b0;
        repeat (8) @(posedge clk_i);
        pulse(6);
        rchk(`ACC_OFF_RIS, 32'h1);
        rchk(`ACC_OFF_MIS, 32'h0);
        `CHK(irq, 1'b0)
        wr(`ACC_OFF_INTEN, 32'h1);
        `CHK(irq, 1'b1)
        // a clear without byte lane 0 must not land
        lanes = 4'hE;
        wr(`ACC_OFF_MIS, 32'h1);
        lanes = 4'hF;
        `CHK(irq, 1'b1)
        wr(`ACC_OFF_MIS, 32'h1);
        `CHK(irq, 1'b0)
        rchk(`ACC_OFF_RIS, 32'h0);
    endtask : t_irq

    // level, fall, rise, both; then the same pulse with the trigger disabled
    task automatic t_trig();
        int exp[4] = '{6, 1, 1, 2};
        logic [15:0] base;
        for (int m = 0; m < 4; m++) begin
            wr(`ACC_OFF_CTL, 32'h888 | 32'(m << 5));
            base = starts;
            pulse(6);
            `CHK(starts - base, 16'(exp[m]))
        end
        wr(`ACC_OFF_CTL, 32'h0C8);
        base = starts;
        pulse(6);
        `CHK(starts - base, 16'h0)
    endtask : t_trig

    task automatic t_split();
        logic [15:0] base;
        wr(`ACC_OFF_CTL, 32'h828);
        wr(`ACC_OFF_MIS, 32'h1);
        `CHK(irq, 1'b0)
        base = starts;
        res <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(irq, 1'b1)
        `CHK(starts - base, 16'h0)
        res <= 1'b0;
        repeat (8) @(posedge clk_i);
        `CHK(starts - base, 16'h1)
    endtask : t_split

    task automatic t_pin();
        wr(`ACC_OFF_PIN, 32'h6);
        `CHK({pin_oe, pin}, 2'b11)
        wr(`ACC_OFF_PIN, 32'h9);
        `CHK({den, pin_oe, pin}, 3'b110)
        res <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(pin, 1'b1)
        // inverted polarity reaches both the status bit and the pin
        wr(`ACC_OFF_CTL, 32'h2);
        rchk(`ACC_OFF_STAT, 32'h0);
        `CHK(pin, 1'b0)
    endtask : t_pin

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_ladder();
        t_source();
        t_irq();
        t_trig();
        t_split();
        t_pin();
        test_done();
    end
endmodule : comparator_control_logic_bench
